// [rtl/fpm_cfg.svh]
// constants for the flash programmer-mode command port
// assumes a 200 MHz system clock and a synchronous pin interface
//
// Overview of operation
// - program one 128-byte block per operation
// - low address byte 00/80, else flag
// - block address taken from second cycle
// - program end seen on polling bits
// - polling bits held until next command
// - erase always clears whole array
// - status read tells abnormal end kind
// - status kept until non-status command
// - status byte flag layout, reset zero
// - polling encodes busy, abnormal, normal
// - ignore commands during startup periods
// - program sequence is 129 write cycles
// - start in read mode, accept commands
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH

// command bytes
`define FPM_CMD_READ        8'h00
`define FPM_CMD_PROG        8'h40
`define FPM_CMD_ERASE       8'h20
`define FPM_CMD_STAT        8'h71

// legal low address bytes of a program block
`define FPM_BLK_LO_A        8'h00
`define FPM_BLK_LO_B        8'h80

// program block geometry
`define FPM_BLK_BYTES       128
`define FPM_BLK_LAST        7'h7f

// status byte bit positions and reset value
`define FPM_ST_ABNORMAL     7
`define FPM_ST_CMD_ERR      6
`define FPM_ST_PROG_ERR     5
`define FPM_ST_ERASE_ERR    4
`define FPM_ST_COUNT_OVER   1
`define FPM_ST_ADDR_ERR     0
`define FPM_ST_RESET        8'h00

// polling bit positions
`define FPM_POLL_DONE       7
`define FPM_POLL_OK         6

// timing
`define FPM_CLK_MHZ         200
`define FPM_T_OSC_MS        10
`define FPM_T_SETUP_MS      10
`define FPM_STARTUP_CYCLES  ((`FPM_T_OSC_MS + `FPM_T_SETUP_MS) * 1000 * `FPM_CLK_MHZ)

`endif

// [rtl/fpm_pkg.sv]
// types and shared helpers of the programmer-mode command port
// assumes fpm_cfg.svh is on the include path
`include "fpm_cfg.svh"

package fpm_pkg;

   typedef logic [7:0] fpm_byte_t;

   // one-hot sequencer states
   typedef enum logic [7:0] {
      FPM_ST_STARTUP = 8'h01,
      FPM_ST_READ    = 8'h02,
      FPM_ST_WAIT    = 8'h04,
      FPM_ST_CMD2    = 8'h08,
      FPM_ST_LOAD    = 8'h10,
      FPM_ST_BUSY    = 8'h20,
      FPM_ST_POLL    = 8'h40,
      FPM_ST_STATUS  = 8'h80
   } fpm_state_e;

   // low address byte of a block transfer is legal
   function automatic logic fpm_blk_aligned(input logic [7:0] lo);
      fpm_blk_aligned = (lo == `FPM_BLK_LO_A) || (lo == `FPM_BLK_LO_B);
   endfunction : fpm_blk_aligned

endpackage : fpm_pkg

// [rtl/fpm_wr_sampler.sv]
// write strobe sampler: one pulse per completed pin write cycle
// assumes pins already synchronous to i_clk_sys
`timescale 1ns/1ps

module fpm_wr_sampler (
   input  wire logic            i_clk_sys,
   input  wire logic            i_rst_n,
   input  wire logic            i_ce_n,
   input  wire logic            i_oe_n,
   input  wire logic            i_we_n,
   input  wire logic [16:0]     i_addr,
   input  wire fpm_pkg::fpm_byte_t i_data,
   output logic                 o_wr_stb,
   output logic [16:0]          o_wr_addr,
   output fpm_pkg::fpm_byte_t   o_wr_data
);
   import fpm_pkg::*;

   logic we_n_q;
   wire  we_rise = i_we_n & ~we_n_q & ~i_ce_n & i_oe_n;

   // edge detect and capture; addr/data sampled on the rising cycle
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         we_n_q    <= 1'b1;
         o_wr_stb  <= 1'b0;
         o_wr_addr <= 17'h00000;
         o_wr_data <= 8'h00;
      end else begin
         we_n_q   <= i_we_n;
         o_wr_stb <= we_rise;
         if (we_rise) begin
            o_wr_addr <= i_addr;
            o_wr_data <= i_data;
         end
      end
   end

   property p_stb_on_rise;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         (i_we_n && !we_n_q && !i_ce_n && i_oe_n) |=> (o_wr_stb && o_wr_data == $past(i_data));
   endproperty
   a_stb_on_rise: assert property (p_stb_on_rise)
      else $error("write strobe rise not sampled");

endmodule : fpm_wr_sampler

// [rtl/fpm_port.sv]
// programmer-mode command port: decodes pin writes, collects a program
// block, starts program/erase in the flash core and answers reads
// assumes synchronous pins and a flash core that pulses i_core_done
`timescale 1ns/1ps
`include "fpm_cfg.svh"

module fpm_port #(
   parameter int unsigned STARTUP_CYCLES = `FPM_STARTUP_CYCLES
) (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst_n,
   input  wire logic               i_ce_n,
   input  wire logic               i_oe_n,
   input  wire logic               i_we_n,
   input  wire logic               i_flash_write_permit_pin,
   input  wire logic [16:0]        i_addr,
   input  wire fpm_pkg::fpm_byte_t i_data,
   output fpm_pkg::fpm_byte_t      o_data,
   output logic                    o_data_oe,
   input  wire logic [6:0]         i_core_buf_idx,
   output fpm_pkg::fpm_byte_t      o_core_buf_data,
   output logic                    o_core_prog_start,
   output logic                    o_core_erase_start,
   output logic [9:0]              o_core_block_addr,
   output logic [16:0]             o_core_rd_addr,
   input  wire fpm_pkg::fpm_byte_t i_core_rd_data,
   input  wire logic               i_core_done,
   input  wire logic               i_core_fail,
   input  wire logic               i_core_count_over,
   output logic                    o_busy,
   output logic                    o_ready
);
   import fpm_pkg::*;

   fpm_state_e state;
   fpm_state_e next_state;
   logic [31:0] cnt;
   logic [6:0]  idx;
   fpm_byte_t   cmd1;
   fpm_byte_t   status;
   logic        op_erase;
   logic        poll_done;
   fpm_byte_t   prog_buf [0:`FPM_BLK_BYTES-1];

   logic        wr_stb;
   logic [16:0] wr_addr;
   fpm_byte_t   wr_data;

   fpm_wr_sampler u_wr (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_ce_n    (i_ce_n),
      .i_oe_n    (i_oe_n),
      .i_we_n    (i_we_n),
      .i_addr    (i_addr),
      .i_data    (i_data),
      .o_wr_stb  (wr_stb),
      .o_wr_addr (wr_addr),
      .o_wr_data (wr_data)
   );

   // command decode; startup and busy states take no command writes
   wire cmd_state = (state == FPM_ST_READ) || (state == FPM_ST_WAIT) ||
                    (state == FPM_ST_POLL) || (state == FPM_ST_STATUS);
   wire wr_cmd    = wr_stb & cmd_state;
   wire is_read   = (wr_data == `FPM_CMD_READ);
   wire is_prog   = (wr_data == `FPM_CMD_PROG);
   wire is_erase  = (wr_data == `FPM_CMD_ERASE);
   wire is_stat   = (wr_data == `FPM_CMD_STAT);
   wire is_known  = is_read | is_prog | is_erase | is_stat;
   wire cnt_done  = (cnt == 32'(STARTUP_CYCLES - 1));
   wire cmd2_wr   = wr_stb & (state == FPM_ST_CMD2);
   wire cmd2_ok   = cmd2_wr & (wr_data == cmd1);
   wire load_wr   = wr_stb & (state == FPM_ST_LOAD);
   wire load_last = load_wr & (idx == `FPM_BLK_LAST);
   wire core_end  = i_core_done & (state == FPM_ST_BUSY);
   wire drive_bus = ~i_ce_n & ~i_oe_n & (state != FPM_ST_STARTUP);

   // entry needs the permit pin high; low is refused as a command error
   wire prog_go   = wr_cmd & is_prog & i_flash_write_permit_pin;
   wire erase_go  = cmd2_ok & (cmd1 == `FPM_CMD_ERASE) & i_flash_write_permit_pin;

   // error events
   wire err_cmd   = (wr_cmd & (~is_known | (is_prog & ~i_flash_write_permit_pin))) |
                    (cmd2_wr & ~cmd2_ok) |
                    (cmd2_ok & (cmd1 == `FPM_CMD_ERASE) & ~i_flash_write_permit_pin);
   wire err_addr  = load_wr & (idx == 7'h00) & ~fpm_blk_aligned(wr_addr[7:0]);
   wire err_prog  = core_end & i_core_fail & ~op_erase;
   wire err_erase = core_end & i_core_fail & op_erase;
   wire err_count = core_end & i_core_count_over;

   // status kept through status read commands, cleared by any other one
   wire st_clr    = wr_cmd & ~is_stat;
   fpm_byte_t st_set;
   fpm_byte_t st_flags;
   fpm_byte_t next_status;
   always_comb begin
      st_set = 8'h00;
      st_set[`FPM_ST_CMD_ERR]    = err_cmd;
      st_set[`FPM_ST_PROG_ERR]   = err_prog;
      st_set[`FPM_ST_ERASE_ERR]  = err_erase;
      st_set[`FPM_ST_COUNT_OVER] = err_count;
      st_set[`FPM_ST_ADDR_ERR]   = err_addr;
      // set wins over clear so an error in the clearing cycle survives
      st_flags = (st_clr ? `FPM_ST_RESET : status) | st_set;
      next_status = st_flags;
      next_status[`FPM_ST_ABNORMAL] = |{st_flags[6:4], st_flags[1:0]};
   end

   wire abnormal = status[`FPM_ST_ABNORMAL];

   // polling byte: 0/0 busy, 1/0 abnormal, 1/1 normal, low bits zero
   fpm_byte_t poll_byte;
   always_comb begin
      poll_byte = 8'h00;
      poll_byte[`FPM_POLL_DONE] = poll_done;
      poll_byte[`FPM_POLL_OK]   = poll_done & ~abnormal;
   end

   // bus source by mode
   wire fpm_byte_t next_data = (state == FPM_ST_READ)   ? i_core_rd_data :
                               (state == FPM_ST_STATUS) ? status :
                               ((state == FPM_ST_BUSY) ||
                                (state == FPM_ST_POLL)) ? poll_byte : 8'h00;

   // sequencer
   always_comb begin
      next_state = state;
      case (state)
         FPM_ST_STARTUP: begin
            if (cnt_done) next_state = FPM_ST_READ;
         end
         FPM_ST_READ, FPM_ST_WAIT, FPM_ST_POLL, FPM_ST_STATUS: begin
            if (wr_cmd) begin
               if (is_read)       next_state = FPM_ST_READ;
               else if (prog_go)  next_state = FPM_ST_LOAD;
               else if (is_erase || is_stat) next_state = FPM_ST_CMD2;
               else               next_state = FPM_ST_WAIT;
            end
         end
         FPM_ST_CMD2: begin
            if (cmd2_wr) begin
               if (erase_go) next_state = FPM_ST_BUSY;
               else if (cmd2_ok && cmd1 == `FPM_CMD_STAT) next_state = FPM_ST_STATUS;
               else next_state = FPM_ST_WAIT;
            end
         end
         FPM_ST_LOAD: begin
            if (load_last) next_state = FPM_ST_BUSY;
         end
         FPM_ST_BUSY: begin
            if (i_core_done) next_state = FPM_ST_POLL;
         end
         default: next_state = FPM_ST_STARTUP;
      endcase
   end

   // state, startup count and sequence registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= FPM_ST_STARTUP;
         cnt   <= 32'h00000000;
         cmd1  <= 8'h00;
         idx   <= 7'h00;
      end else begin
         state <= next_state;
         if (state == FPM_ST_STARTUP) cnt <= cnt + 32'h00000001;
         if (wr_cmd) cmd1 <= wr_data;
         if (wr_cmd) idx <= 7'h00;
         else if (load_wr) idx <= idx + 7'h01;
      end
   end

   // block address held from the first data cycle only
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) o_core_block_addr <= 10'h000;
      else if (load_wr && idx == 7'h00) o_core_block_addr <= wr_addr[16:7];
   end

   // program buffer: byte n of the transfer lands in slot n
   always_ff @(posedge i_clk_sys) begin
      if (load_wr) prog_buf[idx] <= wr_data;
   end

   // operation bookkeeping and flags
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status    <= `FPM_ST_RESET;
         op_erase  <= 1'b0;
         poll_done <= 1'b0;
      end else begin
         status <= next_status;
         if (prog_go) op_erase <= 1'b0;
         else if (erase_go) op_erase <= 1'b1;
         // done flag outlives polling until the next command write
         if (core_end) poll_done <= 1'b1;
         else if (wr_cmd) poll_done <= 1'b0;
      end
   end

   // registered outputs
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data             <= 8'h00;
         o_data_oe          <= 1'b0;
         o_core_buf_data    <= 8'h00;
         o_core_prog_start  <= 1'b0;
         o_core_erase_start <= 1'b0;
         o_core_rd_addr     <= 17'h00000;
         o_busy             <= 1'b0;
         o_ready            <= 1'b0;
      end else begin
         o_data             <= drive_bus ? next_data : 8'h00;
         o_data_oe          <= drive_bus;
         o_core_buf_data    <= prog_buf[i_core_buf_idx];
         o_core_prog_start  <= load_last;
         o_core_erase_start <= erase_go;
         o_core_rd_addr     <= i_addr;
         o_busy             <= (next_state == FPM_ST_BUSY);
         o_ready            <= (next_state != FPM_ST_STARTUP);
      end
   end

   sequence s_last_byte;
      (state == FPM_ST_LOAD) && wr_stb && (idx == `FPM_BLK_LAST);
   endsequence

   sequence s_prog_launch;
      o_core_prog_start && (state == FPM_ST_BUSY);
   endsequence

   property p_prog_launch;
      @(posedge i_clk_sys) disable iff (!i_rst_n) s_last_byte |=> s_prog_launch;
   endproperty
   a_prog_launch: assert property (p_prog_launch)
      else $error("program not started after last block byte");

   property p_no_early_prog;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         ((state == FPM_ST_LOAD) && wr_stb && (idx != `FPM_BLK_LAST)) |=> !o_core_prog_start;
   endproperty
   a_no_early_prog: assert property (p_no_early_prog)
      else $error("program started before block complete");

   property p_addr_err;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         ((state == FPM_ST_LOAD) && wr_stb && idx == 7'h00 && !fpm_blk_aligned(wr_addr[7:0]))
         |=> (status[`FPM_ST_ADDR_ERR] && status[`FPM_ST_ABNORMAL] && state == FPM_ST_LOAD);
   endproperty
   a_addr_err: assert property (p_addr_err)
      else $error("unaligned block address not flagged");

   property p_block_hold;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         ((state == FPM_ST_LOAD) && idx != 7'h00) |=> $stable(o_core_block_addr);
   endproperty
   a_block_hold: assert property (p_block_hold)
      else $error("block address changed after capture");

   property p_startup_quiet;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         (state == FPM_ST_STARTUP) |=> (!o_data_oe && !o_core_prog_start && !o_core_erase_start);
   endproperty
   a_startup_quiet: assert property (p_startup_quiet)
      else $error("activity during startup period");

   property p_busy_poll;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         ((state == FPM_ST_BUSY) && !i_ce_n && !i_oe_n) |=> (o_data_oe && o_data == 8'h00);
   endproperty
   a_busy_poll: assert property (p_busy_poll)
      else $error("polling byte not zero while busy");

   property p_poll_hold;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         (poll_done && !wr_cmd) |=> poll_done [*1] ##0 (state == $past(state));
   endproperty
   a_poll_hold: assert property (p_poll_hold)
      else $error("polling result lost before command write");

   property p_status_keep;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         (wr_cmd && is_stat) |=> (status == $past(status)) ##1 (state == FPM_ST_CMD2);
   endproperty
   a_status_keep: assert property (p_status_keep)
      else $error("status changed by status read command");

   property p_erase_source;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         o_core_erase_start |-> ($past(state) == FPM_ST_CMD2) && (state == FPM_ST_BUSY) && op_erase;
   endproperty
   a_erase_source: assert property (p_erase_source)
      else $error("erase started without confirmed command");

   property p_cmd_err;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
         (wr_cmd && !is_known) |=> (status[`FPM_ST_CMD_ERR] && status[`FPM_ST_ABNORMAL]
                                    && state == FPM_ST_WAIT);
   endproperty
   a_cmd_err: assert property (p_cmd_err)
      else $error("unknown command not flagged");

endmodule : fpm_port

// [verif/fpm_core_model.sv]
// flash core stand-in: takes the program buffer, erases, reports an end
// assumes one stored block is enough; every other block reads erased
`timescale 1ns/1ps

module fpm_core_model (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst_n,
   input  wire logic               i_prog_start,
   input  wire logic               i_erase_start,
   input  wire logic [9:0]         i_block_addr,
   input  wire logic [16:0]        i_rd_addr,
   input  wire fpm_pkg::fpm_byte_t i_buf_data,
   input  wire logic [8:0]         i_delay,
   input  wire logic               i_fail,
   input  wire logic               i_over,
   output logic [6:0]              o_buf_idx,
   output fpm_pkg::fpm_byte_t      o_rd_data,
   output logic                    o_done,
   output logic                    o_fail,
   output logic                    o_over
);
   import fpm_pkg::*;
   fpm_byte_t  mem [128];
   logic [9:0] blk;
   logic [8:0] cnt;
   logic       run;
   logic       prog;

   // flags only valid beside the end pulse, as a real core would
   assign o_rd_data = (i_rd_addr[16:7] == blk) ? mem[i_rd_addr[6:0]] : 8'hff;
   assign o_buf_idx = cnt[6:0];
   assign o_fail    = o_done & i_fail;
   assign o_over    = o_done & i_over;

   // buffer byte n shows one cycle after index n, hence the minus one
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run    <= 1'b0;
         prog   <= 1'b0;
         cnt    <= '0;
         blk    <= 10'h3ff;
         o_done <= 1'b0;
         for (int k = 0; k < 128; k++) mem[k] <= 8'hff;
      end else begin
         o_done <= 1'b0;
         if (i_prog_start || i_erase_start) begin
            run  <= 1'b1;
            cnt  <= '0;
            prog <= i_prog_start;
            blk  <= i_block_addr;
            // erase always clears the whole array
            if (i_erase_start) for (int k = 0; k < 128; k++) mem[k] <= 8'hff;
         end else if (run) begin
            cnt <= cnt + 9'h001;
            if (prog && cnt >= 9'h001 && cnt <= 9'h080) mem[cnt - 9'h001] <= i_buf_data;
            if (cnt == i_delay) begin
               run    <= 1'b0;
               o_done <= 1'b1;
            end
         end
      end
   end
endmodule : fpm_core_model

// [verif/test_flash_programmer_mode_port.sv]
// self-checking bench: the bench acts as the programmer on the pins
// assumes fpm_cfg.svh on the include path and a shortened startup count
`timescale 1ns/1ps
`include "fpm_cfg.svh"

module test_flash_programmer_mode_port;
   import fpm_pkg::*;
   localparam int STARTUP = 20;
   localparam int POLL_START = 20; // scaled stand-in for the polling start wait
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce_n, oe_n, we_n, permit, pstart, estart, done, cfail, cnt_ov, busy, ready;
   logic        doe, fl, ov;
   logic [16:0] addr, rdaddr;
   logic [9:0]  blkaddr;
   logic [8:0]  dly;
   logic [6:0]  idx;
   fpm_byte_t   din, dout, bufd, rdd, d;
   fpm_byte_t   exp_mem[$];
   int          n_errors = 0, num_checks = 0, cyc = 0, np = 0, ne = 0, n;

   fpm_port #(.STARTUP_CYCLES(STARTUP)) u_fpm_port (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_flash_write_permit_pin(permit),
      .i_addr(addr), .i_data(din), .o_data(dout), .o_data_oe(doe), .i_core_buf_idx(idx),
      .o_core_buf_data(bufd), .o_core_prog_start(pstart), .o_core_erase_start(estart),
      .o_core_block_addr(blkaddr), .o_core_rd_addr(rdaddr), .i_core_rd_data(rdd),
      .i_core_done(done), .i_core_fail(cfail), .i_core_count_over(cnt_ov),
      .o_busy(busy), .o_ready(ready));

   fpm_core_model u_fpm_core_model (.i_clk_sys(clk), .i_rst_n(rst_n), .i_prog_start(pstart),
      .i_erase_start(estart), .i_block_addr(blkaddr), .i_rd_addr(rdaddr), .i_buf_data(bufd),
      .i_delay(dly), .i_fail(fl), .i_over(ov), .o_buf_idx(idx), .o_rd_data(rdd),
      .o_done(done), .o_fail(cfail), .o_over(cnt_ov));

   always #2.5 clk = ~clk;

   // start pulses counted so a stuck-high pulse shows up as extra counts
   always @(posedge clk) begin
      cyc++;
      if (pstart === 1'b1) np++;
      if (estart === 1'b1) ne++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // byte taken on the strobe rise; three quiet cycles keep the spacing
   task automatic pwr(input logic [16:0] a, input fpm_byte_t v);
      @(posedge clk);
      ce_n <= 1'b0;
      oe_n <= 1'b1;
      we_n <= 1'b0;
      addr <= a;
      din  <= v;
      repeat (2) @(posedge clk);
      we_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : pwr

   // address held steady so the two-cycle read path has settled
   task automatic prd(input logic [16:0] a, output fpm_byte_t v);
      @(posedge clk);
      oe_n <= 1'b0;
      addr <= a;
      repeat (3) @(posedge clk);
      #1;
      chk("bus drive", 10'h001, {9'h000, doe});
      v = dout;
      @(posedge clk);
      oe_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("bus release", 10'h000, {9'h000, doe});
   endtask : prd

   task automatic stat(input fpm_byte_t e);
      fpm_byte_t v;
      pwr(17'h0, `FPM_CMD_STAT);
      pwr(17'h0, `FPM_CMD_STAT);
      prd(17'h0, v);
      chk("status", {2'b00, e}, {2'b00, v});
   endtask : stat

   // first read always lands while the core is still busy
   task automatic poll(input fpm_byte_t e);
      fpm_byte_t v;
      int        k;
      repeat (POLL_START) @(posedge clk); // first read still lands while busy
      prd(17'h0, v);
      chk("poll busy", 10'h000, {2'b00, v});
      k = 0;
      while (v[7] !== 1'b1 && k < 200) begin
         prd(17'h0, v);
         k++;
      end
      chk("poll end", {2'b00, e}, {2'b00, v});
      prd(17'h0, v);
      chk("poll held", {2'b00, e}, {2'b00, v});
   endtask : poll

   task automatic prog(input logic [16:0] a, input logic f, input logic o, input fpm_byte_t e);
      fpm_byte_t b;
      int        p0;
      fl <= f;
      ov <= o;
      p0 = np;
      exp_mem.delete();
      pwr(17'h0, `FPM_CMD_PROG);
      for (int k = 0; k < 128; k++) begin
         b = (k < 120) ? 8'($urandom) : 8'hff; // unused tail padded
         exp_mem.push_back(b);
         pwr(a + 17'(k), b);
      end
      chk("busy", 10'h001, {9'h000, busy});
      chk("block", a[16:7], blkaddr);
      poll(e);
      chk("start pulses", 10'h001, 10'(np - p0));
   endtask : prog

   task automatic ers(input logic f);
      int e0;
      fl <= f;
      ov <= 1'b0;
      e0 = ne;
      pwr(17'h0, `FPM_CMD_ERASE);
      pwr(17'h0, `FPM_CMD_ERASE);
      chk("erase busy", 10'h001, {9'h000, busy});
      poll(f ? 8'h80 : 8'hc0);
      chk("erase pulses", 10'h001, 10'(ne - e0));
   endtask : ers

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   initial begin
      ce_n   = 1'b1;
      oe_n   = 1'b1;
      we_n   = 1'b1;
      permit = 1'b1; // high for program and erase entry
      addr   = '0;
      din    = '0;
      dly    = 9'd200;
      fl     = 1'b0;
      ov     = 1'b0;
      void'($urandom(32'h73d229c5));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      pwr(17'h0, 8'h33); // lands before ready, must leave no flag
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ready !== 1'b1 && n < 100);
      chk("ready delay", 10'(STARTUP - 6), 10'(n));
      prd(17'h00100, d);
      chk("power-on read", 10'h0ff, {2'b00, d});
      stat(8'h00);
      ers(1'b0); // history unknown, erase first
      $display("test startup done");
      prog(17'h12380, 1'b0, 1'b0, 8'hc0); // every block once per erase
      stat(8'h00);
      pwr(17'h0, `FPM_CMD_READ);
      for (int k = 0; k < 6; k++) begin
         n = (k == 5) ? 127 : int'($urandom % 128);
         prd(17'h12380 + 17'(n), d);
         chk("array", {2'b00, exp_mem[n]}, {2'b00, d});
      end
      $display("test program done");
      prog(17'h0a305, 1'b0, 1'b0, 8'h80);
      stat(8'h81);
      prog(17'h04000, 1'b1, 1'b0, 8'h80);
      stat(8'ha0);
      stat(8'ha0);
      prog(17'h04080, 1'b1, 1'b1, 8'h80);
      stat(8'ha2);
      $display("test program errors done");
      ers(1'b0);
      stat(8'h00);
      pwr(17'h0, `FPM_CMD_READ);
      prd(17'h12380, d);
      chk("erased", 10'h0ff, {2'b00, d});
      prog(17'h12380, 1'b0, 1'b0, 8'hc0); // used block erased first
      ers(1'b1);
      stat(8'h90);
      $display("test erase done");
      pwr(17'h0, 8'h33);
      stat(8'hc0);
      pwr(17'h0, `FPM_CMD_ERASE);
      pwr(17'h0, 8'h21);
      stat(8'hc0);
      pwr(17'h0, `FPM_CMD_STAT);
      pwr(17'h0, 8'h70);
      stat(8'hc0);
      permit <= 1'b0;
      pwr(17'h0, `FPM_CMD_PROG);
      permit <= 1'b1;
      stat(8'hc0);
      pwr(17'h0, `FPM_CMD_READ);
      stat(8'h00);
      $display("test command errors done");
      wrap_up();
   end
endmodule : test_flash_programmer_mode_port
